/* File: rtl/uart_efc_pkg.sv */
/*
  Constants shared by the enhanced flow control channel and its character matcher:
  register offsets, field positions, reset values and state codes.
  Assumes a single sys_clk domain and a byte-wide register port.
*/
package uart_efc_pkg;
  // ==========================================================================
  // Register offsets (5-bit register port address)
  localparam logic [4:0] OFF_RX_DATA      = 5'h00;
  localparam logic [4:0] OFF_INT_ENABLE   = 5'h01;
  localparam logic [4:0] OFF_INT_STATUS   = 5'h02; // Read side
  localparam logic [4:0] OFF_FIFO_CONTROL = 5'h02; // Write side
  localparam logic [4:0] OFF_LINE_CONTROL = 5'h03;
  localparam logic [4:0] OFF_MODEM_CTRL   = 5'h04;
  localparam logic [4:0] OFF_LINE_STATUS  = 5'h05;
  localparam logic [4:0] OFF_MODEM_STATUS = 5'h06;
  localparam logic [4:0] OFF_SCRATCH      = 5'h07;
  localparam logic [4:0] OFF_ENH_FEATURE  = 5'h08;
  localparam logic [4:0] OFF_RESUME_1     = 5'h09;
  localparam logic [4:0] OFF_RESUME_2     = 5'h0A;
  localparam logic [4:0] OFF_PAUSE_1      = 5'h0B;
  localparam logic [4:0] OFF_PAUSE_2      = 5'h0C;
  localparam logic [4:0] OFF_DIVISOR_LOW  = 5'h0D;
  localparam logic [4:0] OFF_DIVISOR_HIGH = 5'h0E;
  localparam logic [4:0] OFF_EVENT_STATUS = 5'h10;
  localparam logic [4:0] OFF_EVENT_MASK   = 5'h11;

  // ==========================================================================
  // Field positions
  localparam int EFR_GATE_BIT    = 4;
  localparam int EFR_SPECIAL_BIT = 5;
  localparam int MCR_DTR_BIT     = 0;
  localparam int MCR_RTS_BIT     = 1;
  localparam int MCR_OUT2_BIT    = 3;
  localparam int EV_SPECIAL      = 0;
  localparam int EV_PAUSE_RX     = 1;
  localparam int EV_RESUME_RX    = 2;
  localparam int EV_MODEM        = 3;
  localparam int EV_W            = 4;

  // ==========================================================================
  // Reset values and flow selection codes
  localparam logic [7:0] SCRATCH_RST  = 8'hFF;
  localparam logic [1:0] LSR_TX_RST   = 2'h3;
  localparam logic [1:0] SEL_NONE     = 2'h0;
  localparam logic [1:0] SEL_SECOND   = 2'h1;
  localparam logic [1:0] SEL_FIRST    = 2'h2;
  localparam logic [1:0] SEL_BOTH     = 2'h3;

  typedef enum logic [1:0] {
    TX_IDLE   = 2'b00,
    TX_FIRST  = 2'b01,
    TX_SECOND = 2'b10
  } tx_state_e;
endpackage

/* File: rtl/flow_match_if.sv */
/*
  Bundle between the channel control and the received-character matcher.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/100ps
interface flow_match_if;
  logic [7:0] resume_first;
  logic [7:0] resume_second;
  logic [7:0] pause_first;
  logic [7:0] pause_second;
  logic [1:0] rx_sel;
  logic       special_en;
  logic       rx_valid;
  logic [7:0] rx_char;
  logic       pause_hit;
  logic       resume_hit;
  logic       special_hit;
  logic       swallow;

  modport ctrl (output resume_first, resume_second, pause_first, pause_second,
                output rx_sel, special_en, rx_valid, rx_char,
                input  pause_hit, resume_hit, special_hit, swallow);
  modport match (input  resume_first, resume_second, pause_first, pause_second,
                 input  rx_sel, special_en, rx_valid, rx_char,
                 output pause_hit, resume_hit, special_hit, swallow);
endinterface

/* File: rtl/flow_char_matcher.sv */
/*
  Compares each received character against the pause, resume and special
  characters. Holds one bit of sequence state per kind for two-character mode.
  Assumes rx_valid is a one-cycle strobe per received character.
*/
`timescale 1ns/100ps
module flow_char_matcher (
  input wire logic   sys_clk,
  input wire logic   sys_rst,
  flow_match_if.match fm
);
  logic pend_pause;
  logic pend_resume;

  // ==========================================================================
  // Full 8-bit equality of each character register against the received character
  wire eq_p1 = (fm.rx_char == fm.pause_first);
  wire eq_p2 = (fm.rx_char == fm.pause_second);
  wire eq_r1 = (fm.rx_char == fm.resume_first);
  wire eq_r2 = (fm.rx_char == fm.resume_second);
  wire both  = (fm.rx_sel == uart_efc_pkg::SEL_BOTH);

  // Single-pair or sequence hits per receive selection
  wire pause_raw  = (fm.rx_sel == uart_efc_pkg::SEL_FIRST)  ? eq_p1 :
                    (fm.rx_sel == uart_efc_pkg::SEL_SECOND) ? eq_p2 :
                    both ? (pend_pause & eq_p2) : 1'b0;
  wire resume_raw = (fm.rx_sel == uart_efc_pkg::SEL_FIRST)  ? eq_r1 :
                    (fm.rx_sel == uart_efc_pkg::SEL_SECOND) ? eq_r2 :
                    both ? (pend_resume & eq_r2) : 1'b0;

  assign fm.pause_hit   = fm.rx_valid & pause_raw;
  assign fm.resume_hit  = fm.rx_valid & resume_raw;
  // Special match goes on to the FIFO unless it is also a flow hit
  assign fm.special_hit = fm.rx_valid & fm.special_en & eq_p2;
  // Flow hits never reach the FIFO as payload; the first half of a two-character sequence does
  assign fm.swallow     = fm.pause_hit | fm.resume_hit;

  // Sequence memory: first half seen on the previous character
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_pause  <= 1'b0;
      pend_resume <= 1'b0;
    end else if (fm.rx_valid) begin
      pend_pause  <= both & eq_p1;
      pend_resume <= both & eq_r1;
    end
  end
endmodule

/* File: rtl/uart_enhanced_flow_control.sv */
/*
  One UART channel's enhanced feature control: register port, enhanced-bit
  gating with save and restore, in-band flow character send and match, special
  character detection, reset states of status registers and pins, interrupt.
  Assumes the receiver delivers whole characters on rx_valid/rx_char, the
  transmitter accepts flow characters on a valid/ready pair, and all inputs
  are synchronous to sys_clk.
*/
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module uart_enhanced_flow_control (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_char,
  output logic            fifo_valid,
  output logic      [7:0] fifo_char,
  input  wire logic       tx_pause_req,
  input  wire logic       tx_resume_req,
  output logic            tx_flow_valid,
  output logic      [7:0] tx_flow_char,
  input  wire logic       tx_flow_ready,
  output logic            tx_halt,
  input  wire logic       tx_serial,
  input  wire logic [1:0] tx_idle,
  input  wire logic [3:0] modem_in,
  output logic            serial_out_a,
  output logic            gp_output2_a,
  output logic            request_to_send_a,
  output logic            terminal_ready_a,
  output logic            irq_out_a,
  output logic            irq_oe_a
);
  // ==========================================================================
  // Register storage
  logic [3:0] ier_lo;
  logic [3:0] ier_hi;
  logic [3:0] fcr_a;
  logic [1:0] fcr_enh;
  logic [1:0] fcr_b;
  logic [7:0] line_control;
  logic [4:0] mcr_lo;
  logic [2:0] mcr_hi;
  logic [1:0] isr_enh;
  logic [7:0] enhanced_feature_control;
  logic [7:0] resume_char_first;
  logic [7:0] resume_char_second;
  logic [7:0] pause_char_first;
  logic [7:0] pause_char_second;
  logic [7:0] scratch_byte;
  logic [7:0] divisor_low;
  logic [7:0] divisor_high;
  logic [7:0] rx_data;
  logic       data_ready;
  logic       overrun;
  logic [1:0] lsr_tx;
  logic [3:0] modem_prev;
  logic [3:0] modem_delta;
  logic [uart_efc_pkg::EV_W-1:0] event_status;
  logic [uart_efc_pkg::EV_W-1:0] event_mask;
  // Saved copies of the gated bits while the gate is closed
  logic [3:0] sav_ier;
  logic [1:0] sav_fcr;
  logic [2:0] sav_mcr;
  logic [1:0] sav_isr;
  uart_efc_pkg::tx_state_e tx_state;
  logic       tx_kind_pause;
  logic       serial_q;

  flow_match_if fm ();

  flow_char_matcher u_matcher (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .fm      (fm)
  );

  // ==========================================================================
  // Decode
  wire gate      = enhanced_feature_control[uart_efc_pkg::EFR_GATE_BIT];
  wire [1:0] tx_sel = enhanced_feature_control[3:2];
  wire [1:0] rx_sel = enhanced_feature_control[1:0];
  wire wr_ier    = wr & (addr == uart_efc_pkg::OFF_INT_ENABLE);
  wire wr_fcr    = wr & (addr == uart_efc_pkg::OFF_FIFO_CONTROL);
  wire wr_lcr    = wr & (addr == uart_efc_pkg::OFF_LINE_CONTROL);
  wire wr_mcr    = wr & (addr == uart_efc_pkg::OFF_MODEM_CTRL);
  wire wr_efr    = wr & (addr == uart_efc_pkg::OFF_ENH_FEATURE);
  wire wr_evs    = wr & (addr == uart_efc_pkg::OFF_EVENT_STATUS);
  wire wr_evm    = wr & (addr == uart_efc_pkg::OFF_EVENT_MASK);
  wire rd_rx     = rd & (addr == uart_efc_pkg::OFF_RX_DATA);
  wire rd_isr    = rd & (addr == uart_efc_pkg::OFF_INT_STATUS);
  wire rd_lsr    = rd & (addr == uart_efc_pkg::OFF_LINE_STATUS);
  wire rd_msr    = rd & (addr == uart_efc_pkg::OFF_MODEM_STATUS);
  wire new_gate  = wdata[uart_efc_pkg::EFR_GATE_BIT];
  wire gate_fall = wr_efr & gate & ~new_gate;
  wire gate_rise = wr_efr & ~gate & new_gate;
  wire [7:0] modem_control = {mcr_hi, mcr_lo};

  // Matcher hookup
  assign fm.resume_first  = resume_char_first;
  assign fm.resume_second = resume_char_second;
  assign fm.pause_first   = pause_char_first;
  assign fm.pause_second  = pause_char_second;
  assign fm.rx_sel        = rx_sel;
  assign fm.special_en    = enhanced_feature_control[uart_efc_pkg::EFR_SPECIAL_BIT];
  assign fm.rx_valid      = rx_valid;
  assign fm.rx_char       = rx_char;

  // Event sources; the interrupt pin reads the sticky copy
  wire [uart_efc_pkg::EV_W-1:0] ev_set = {|(modem_in ^ modem_prev), fm.resume_hit,
                                          fm.pause_hit, fm.special_hit};
  wire irq_any = |(event_status & event_mask);
  wire [7:0] isr_val = {2'h0, isr_enh, 3'h0, ~irq_any};
  wire [7:0] lsr_val = {1'b0, lsr_tx, 3'h0, overrun, data_ready};
  wire [7:0] msr_val = {modem_in, modem_delta};
  wire store     = rx_valid & ~fm.swallow;

  // ==========================================================================
  // Read mux; unmapped offsets read zero
  logic [7:0] next_rdata;
  always_comb begin
    unique case (addr)
      uart_efc_pkg::OFF_RX_DATA:      next_rdata = rx_data;
      uart_efc_pkg::OFF_INT_ENABLE:   next_rdata = {ier_hi, ier_lo};
      uart_efc_pkg::OFF_INT_STATUS:   next_rdata = isr_val;
      uart_efc_pkg::OFF_LINE_CONTROL: next_rdata = line_control;
      uart_efc_pkg::OFF_MODEM_CTRL:   next_rdata = modem_control;
      uart_efc_pkg::OFF_LINE_STATUS:  next_rdata = lsr_val;
      uart_efc_pkg::OFF_MODEM_STATUS: next_rdata = msr_val;
      uart_efc_pkg::OFF_SCRATCH:      next_rdata = scratch_byte;
      uart_efc_pkg::OFF_ENH_FEATURE:  next_rdata = enhanced_feature_control;
      uart_efc_pkg::OFF_RESUME_1:     next_rdata = resume_char_first;
      uart_efc_pkg::OFF_RESUME_2:     next_rdata = resume_char_second;
      uart_efc_pkg::OFF_PAUSE_1:      next_rdata = pause_char_first;
      uart_efc_pkg::OFF_PAUSE_2:      next_rdata = pause_char_second;
      uart_efc_pkg::OFF_DIVISOR_LOW:  next_rdata = divisor_low;
      uart_efc_pkg::OFF_DIVISOR_HIGH: next_rdata = divisor_high;
      uart_efc_pkg::OFF_EVENT_STATUS: next_rdata = {4'h0, event_status};
      uart_efc_pkg::OFF_EVENT_MASK:   next_rdata = {4'h0, event_mask};
      default:                        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  // ==========================================================================
  // Plain control registers, not touched by the gate
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ier_lo                   <= 4'h0;
      fcr_a                    <= 4'h0;
      fcr_b                    <= 2'h0;
      line_control             <= 8'h00;
      mcr_lo                   <= 5'h00;
      enhanced_feature_control <= 8'h00;
      scratch_byte             <= uart_efc_pkg::SCRATCH_RST;
      event_mask               <= '0;
    end else begin
      if (wr_ier) ier_lo <= wdata[3:0];
      if (wr_fcr) begin
        fcr_a <= wdata[3:0];
        fcr_b <= wdata[7:6];
      end
      if (wr_lcr) line_control <= wdata;
      if (wr_mcr) mcr_lo <= wdata[4:0];
      if (wr_efr) enhanced_feature_control <= wdata;
      if (wr && addr == uart_efc_pkg::OFF_SCRATCH) scratch_byte <= wdata;
      if (wr_evm) event_mask <= wdata[uart_efc_pkg::EV_W-1:0];
    end
  end

  // Character and divisor registers hold no defined reset value
  always_ff @(posedge sys_clk) begin
    if (wr && addr == uart_efc_pkg::OFF_RESUME_1) resume_char_first <= wdata;
    if (wr && addr == uart_efc_pkg::OFF_RESUME_2) resume_char_second <= wdata;
    if (wr && addr == uart_efc_pkg::OFF_PAUSE_1) pause_char_first <= wdata;
    if (wr && addr == uart_efc_pkg::OFF_PAUSE_2) pause_char_second <= wdata;
    if (wr && addr == uart_efc_pkg::OFF_DIVISOR_LOW) divisor_low <= wdata;
    if (wr && addr == uart_efc_pkg::OFF_DIVISOR_HIGH) divisor_high <= wdata;
  end

  // ==========================================================================
  // Gated enhanced bits: writable only with the gate open, saved and zeroed
  // when it closes, restored when it opens. Legacy drivers that never open
  // the gate therefore cannot disturb them.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ier_hi  <= 4'h0;
      fcr_enh <= 2'h0;
      mcr_hi  <= 3'h0;
      isr_enh <= 2'h0;
      sav_ier <= 4'h0;
      sav_fcr <= 2'h0;
      sav_mcr <= 3'h0;
      sav_isr <= 2'h0;
    end else if (gate_fall) begin
      sav_ier <= ier_hi;
      sav_fcr <= fcr_enh;
      sav_mcr <= mcr_hi;
      sav_isr <= isr_enh;
      ier_hi  <= 4'h0;
      fcr_enh <= 2'h0;
      mcr_hi  <= 3'h0;
      isr_enh <= 2'h0;
    end else if (gate_rise) begin
      ier_hi  <= sav_ier;
      fcr_enh <= sav_fcr;
      mcr_hi  <= sav_mcr;
      isr_enh <= sav_isr;
    end else if (gate) begin
      if (wr_ier) ier_hi <= wdata[7:4];
      if (wr_fcr) fcr_enh <= wdata[5:4];
      if (wr_mcr) mcr_hi <= wdata[7:5];
      // Special-detect flag: set wins over the read that clears it
      isr_enh[0] <= fm.special_hit | (isr_enh[0] & ~rd_isr);
      isr_enh[1] <= tx_halt;
    end
  end

  // ==========================================================================
  // Receive path: matched flow symbols are dropped, everything else stored
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fifo_valid <= 1'b0;
      fifo_char  <= 8'h00;
      rx_data    <= 8'h00;
      data_ready <= 1'b0;
      overrun    <= 1'b0;
      tx_halt    <= 1'b0;
    end else begin
      fifo_valid <= store;
      if (store) begin
        fifo_char <= rx_char;
        rx_data   <= rx_char;
      end
      data_ready <= store | (data_ready & ~rd_rx);
      overrun    <= (store & data_ready & ~rd_rx) | (overrun & ~rd_lsr);
      // Remote pause holds our transmitter until the resume symbol
      if (rx_sel == uart_efc_pkg::SEL_NONE) tx_halt <= 1'b0;
      else if (fm.pause_hit) tx_halt <= 1'b1;
      else if (fm.resume_hit) tx_halt <= 1'b0;
    end
  end

  // ==========================================================================
  // Line and modem status snapshots
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lsr_tx      <= uart_efc_pkg::LSR_TX_RST;
      // Track the live pins in reset so no false delta follows its release
      modem_prev  <= modem_in;
      modem_delta <= 4'h0;
    end else begin
      lsr_tx      <= tx_idle;
      modem_prev  <= modem_in;
      // Change sets a delta bit, winning over the clearing read
      modem_delta <= (modem_in ^ modem_prev) | (modem_delta & {4{~rd_msr}});
    end
  end

  // ==========================================================================
  // Sticky events, write one to clear, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      event_status <= '0;
    end else begin
      event_status <= ev_set |
                      (event_status & ~(wr_evs ? wdata[uart_efc_pkg::EV_W-1:0] : '0));
    end
  end

  // ==========================================================================
  // Transmit flow symbol sender; requests arriving while busy are dropped
  wire [7:0] kind_first  = tx_kind_pause ? pause_char_first : resume_char_first;
  wire [7:0] kind_second = tx_kind_pause ? pause_char_second : resume_char_second;
  wire       req_any     = tx_pause_req | tx_resume_req;
  wire [7:0] req_first   = tx_pause_req ? pause_char_first : resume_char_first;
  wire [7:0] req_second  = tx_pause_req ? pause_char_second : resume_char_second;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_state      <= uart_efc_pkg::TX_IDLE;
      tx_kind_pause <= 1'b0;
      tx_flow_char  <= 8'h00;
    end else begin
      unique case (tx_state)
        uart_efc_pkg::TX_IDLE: begin
          if (req_any && tx_sel != uart_efc_pkg::SEL_NONE) begin
            tx_state      <= uart_efc_pkg::TX_FIRST;
            tx_kind_pause <= tx_pause_req;  // Pause outranks resume
            tx_flow_char  <= (tx_sel == uart_efc_pkg::SEL_SECOND) ?
                             req_second : req_first;
          end
        end
        uart_efc_pkg::TX_FIRST: begin
          if (tx_flow_ready) begin
            if (tx_sel == uart_efc_pkg::SEL_BOTH) begin
              tx_state     <= uart_efc_pkg::TX_SECOND;
              tx_flow_char <= kind_second;
            end else begin
              tx_state <= uart_efc_pkg::TX_IDLE;
            end
          end
        end
        uart_efc_pkg::TX_SECOND: begin
          if (tx_flow_ready) tx_state <= uart_efc_pkg::TX_IDLE;
        end
        default: begin
          tx_state     <= uart_efc_pkg::TX_IDLE;
          tx_flow_char <= kind_first;
        end
      endcase
    end
  end

  assign tx_flow_valid = (tx_state != uart_efc_pkg::TX_IDLE);

  // ==========================================================================
  // Pins: modem outputs are active low, so zeroed controls give high pins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_q <= 1'b1;
    end else begin
      serial_q <= tx_serial;
    end
  end

  assign serial_out_a      = serial_q | sys_rst;
  assign gp_output2_a      = ~modem_control[uart_efc_pkg::MCR_OUT2_BIT] | sys_rst;
  assign request_to_send_a = ~modem_control[uart_efc_pkg::MCR_RTS_BIT] | sys_rst;
  assign terminal_ready_a  = ~modem_control[uart_efc_pkg::MCR_DTR_BIT] | sys_rst;
  assign irq_out_a         = irq_any & ~sys_rst;
  // Interrupt pin floats in reset and while the output enable bit is clear
  assign irq_oe_a          = modem_control[uart_efc_pkg::MCR_OUT2_BIT] & ~sys_rst;
endmodule

/* File: verification/uart_efc_assertions.sv */
/*
  Port checker for the enhanced flow control channel.
  Assumes it is bound to the top module and everything runs on sys_clk.
*/
`timescale 1ns/100ps
module uart_efc_checker (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic [4:0] addr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic       fifo_valid,
  input wire logic [7:0] fifo_char,
  input wire logic       tx_flow_valid,
  input wire logic [7:0] tx_flow_char,
  input wire logic       tx_flow_ready,
  input wire logic       tx_halt,
  input wire logic [3:0] modem_in,
  input wire logic       serial_out_a,
  input wire logic       gp_output2_a,
  input wire logic       request_to_send_a,
  input wire logic       terminal_ready_a,
  input wire logic       irq_out_a,
  input wire logic       irq_oe_a
);
  default clocking cb @(posedge sys_clk);
  endclocking
  // ==========================================================================
  // Reset states; these must hold inside reset, so no disable there
  property p_rst_pins;
    sys_rst |-> serial_out_a && gp_output2_a && request_to_send_a && terminal_ready_a;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not high in reset");
  property p_rst_irq; sys_rst |-> !irq_out_a && !irq_oe_a; endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq pin driven in reset");
  property p_isr_rst; sys_rst ##1 !sys_rst ##1 (rd && addr == 5'h02) |=> rdata == 8'h01; endproperty
  a_isr_rst: assert property (p_isr_rst) else $error("status not idle after reset");
  // ==========================================================================
  // Run-time relations between inputs and outputs
  property p_msr_live;
    disable iff (sys_rst) rd && addr == 5'h06 |=> rdata == {$past(modem_in), 4'h0};
  endproperty
  a_msr_live: assert property (p_msr_live) else $error("modem status wrong");
  property p_fifo_store;
    disable iff (sys_rst) fifo_valid |-> $past(rx_valid) && fifo_char == $past(rx_char);
  endproperty
  a_fifo_store: assert property (p_fifo_store) else $error("stored char wrong");
  property p_halt_cause; disable iff (sys_rst) $rose(tx_halt) |-> $past(rx_valid); endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without char");
  property p_halt_swallow; disable iff (sys_rst) $rose(tx_halt) |-> !fifo_valid; endproperty
  a_halt_swallow: assert property (p_halt_swallow) else $error("pause char stored");
  property p_flow_hold;
    disable iff (sys_rst) tx_flow_valid && !tx_flow_ready |=> tx_flow_valid && $stable(tx_flow_char);
  endproperty
  a_flow_hold: assert property (p_flow_hold) else $error("flow char dropped");
  cover property (fifo_valid);
  cover property ($rose(tx_halt));
  cover property (tx_flow_valid && tx_flow_ready);
endmodule
bind uart_enhanced_flow_control uart_efc_checker i_uart_efc_checker (.*);

/* File: verification/flow_sink_model.sv */
/*
  Remote-side sink for in-band flow symbols, stalled on command.
  Assumes the sys_clk domain and a valid/ready pair from the channel.
*/
`timescale 1ns/100ps
module flow_sink_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        stall,
  input  wire logic        tx_flow_valid,
  input  wire logic [7:0]  tx_flow_char,
  output logic             tx_flow_ready,
  output logic      [1:0]  tx_idle,
  output logic             tx_serial,
  output logic      [15:0] got
);
  // Ready only while offered, so a stall really holds the symbol
  assign tx_flow_ready = tx_flow_valid & ~stall;
  assign tx_idle       = tx_flow_valid ? 2'h0 : 2'h3;
  assign tx_serial     = 1'h1; // Line rests at mark
  // Last two symbols taken, kept apart from payload
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      got <= 16'h0000;
    else if (tx_flow_ready)
      got <= {got[7:0], tx_flow_char};
  end
endmodule

/* File: verification/uart_enhanced_flow_control_tb.sv */
/*
  Self-checking bench for the enhanced flow control channel.
  Assumes the sink model on the flow side and the bound port checker.
*/
`timescale 1ns/100ps
module uart_enhanced_flow_control_tb;
  logic        sys_clk = 1'h0, sys_rst = 1'h1, wr = 1'h0, rd = 1'h0, rx_valid = 1'h0;
  logic        tx_pause_req = 1'h0, tx_resume_req = 1'h0, stall = 1'h0;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wdata = 8'h00, rx_char = 8'h00, rdata, fifo_char, tx_flow_char;
  logic        fifo_valid, tx_flow_valid, tx_flow_ready, tx_halt, tx_serial;
  logic        serial_out_a, gp_output2_a, request_to_send_a, terminal_ready_a;
  logic        irq_out_a, irq_oe_a;
  logic [1:0]  tx_idle;
  logic [3:0]  modem_in = 4'h0;
  logic [15:0] got, ex;
  logic [7:0]  ch [4]; // Pause first, pause second, resume first, resume second
  int          seed = 66, fail_count = 0, tests_run = 0, i, n;

  always #2 sys_clk = ~sys_clk;
  uart_enhanced_flow_control i_uart_enhanced_flow_control (.*);
  flow_sink_model i_flow_sink_model (.*);

  // ==========================================================================
  // Compare, bus and receive helpers
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
    @(posedge sys_clk) {wr, addr, wdata} <= {1'h1, a, v};
    @(posedge sys_clk) wr <= 1'h0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    @(posedge sys_clk) {rd, addr} <= {1'h1, a};
    @(posedge sys_clk) rd <= 1'h0;
    #1 chk($sformatf("register %h", a), e, rdata);
  endtask
  task automatic rx(input logic [7:0] c, input logic fv, input logic h);
    @(posedge sys_clk) {rx_valid, rx_char} <= {1'h1, c};
    @(posedge sys_clk) rx_valid <= 1'h0;
    #1 chk("fifo_valid", fv, fifo_valid);
    if (fv) chk("fifo_char", c, fifo_char);
    chk("tx_halt", h, tx_halt);
  endtask
  // Symbols expected at the sink for a transmit selection
  function automatic logic [15:0] tx_exp(input logic [1:0] s, input int b, input logic [15:0] g);
    if (s[1]) g = {g[7:0], ch[b]};
    if (s[0]) g = {g[7:0], ch[b + 1]};
    return g;
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence; flow chars have bit 7 set so payload never collides
  initial begin
    for (i = 0; i < 4; i++) ch[i] = {1'h1, 2'(i), 5'($random(seed))};
    modem_in = 4'($random(seed));
    repeat (15) @(posedge sys_clk);
    #1 chk("reset pins", 16'h000F, {irq_oe_a, irq_out_a, serial_out_a, gp_output2_a,
                                     request_to_send_a, terminal_ready_a});
    @(posedge sys_clk) sys_rst <= 1'h0;
    rd_chk(5'h02, 8'h01);
    rd_chk(5'h05, 8'h60);
    rd_chk(5'h06, {modem_in, 4'h0});
    rd_chk(5'h01, 8'h00);
    rd_chk(5'h03, 8'h00);
    rd_chk(5'h04, 8'h00);
    rd_chk(5'h08, 8'h00);
    rd_chk(5'h07, 8'hFF);
    wr_reg(5'h08, 8'h10);
    wr_reg(5'h01, 8'hF5);
    rd_chk(5'h01, 8'hF5);
    wr_reg(5'h08, 8'h00);
    rd_chk(5'h01, 8'h05);
    wr_reg(5'h01, 8'hF7);
    rd_chk(5'h01, 8'h07);
    wr_reg(5'h08, 8'h10);
    rd_chk(5'h01, 8'hF7);
    rd_chk(5'h1F, 8'h00);
    for (i = 0; i < 4; i++) wr_reg(5'h09 + 5'(i ^ 2), ch[i]);
    // Every transmit selection, pause and resume alternating, sink stalling
    for (i = 0; i < 4; i++) begin
      wr_reg(5'h08, {4'h1, 2'(i), 2'h0});
      ex = tx_exp(2'(i), 2 * i[0], got);
      @(posedge sys_clk) {tx_pause_req, tx_resume_req} <= {~i[0], i[0]};
      @(posedge sys_clk) {tx_pause_req, tx_resume_req} <= 2'h0;
      for (n = 0; n < 40 && got !== ex; n++) @(posedge sys_clk) stall <= $random(seed) & $random(seed);
      @(posedge sys_clk) stall <= 1'h0;
      #1 chk("flow symbols", ex, got);
      repeat (3) @(posedge sys_clk);
      #1 chk("tx_flow_valid", 16'h0000, tx_flow_valid);
    end
    // Receive selections second, first and both: pause, resume, then payload
    for (i = 1; i < 4; i++) begin
      wr_reg(5'h08, {6'h04, 2'(i)});
      if (i == 3) rx(ch[0], 1'h1, 1'h0);
      rx(ch[i[0]], 1'h0, 1'h1);
      if (i == 3) rx(ch[2], 1'h1, 1'h1);
      rx(ch[2 + i[0]], 1'h0, 1'h0);
      rx(8'($random(seed)) & 8'h7F, 1'h1, 1'h0);
    end
    wr_reg(5'h10, 8'hFF);
    wr_reg(5'h11, 8'h01);
    wr_reg(5'h04, 8'h08);
    wr_reg(5'h08, 8'h30);
    rx(ch[1], 1'h1, 1'h0);
    chk("irq pin", 16'h0003, {irq_oe_a, irq_out_a});
    rd_chk(5'h02, 8'h10);
    rd_chk(5'h02, 8'h00);
    wr_reg(5'h10, 8'h01);
    #1 chk("irq pin", 16'h0002, {irq_oe_a, irq_out_a});
    rd_chk(5'h02, 8'h01);
    wrap_up();
  end
endmodule
